// ===== core/pfm_controller.sv
// packet fifo mode controller: 64-byte tx and rx buffers, four fifo modes,
// serial bit path toward the packet handler, byte-wide register port
// assumes the link clock and rx bit come from another domain
`timescale 1ns/1ps
`default_nettype none

module pfm_controller #(
   parameter int DEPTH = 64
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [pfm_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [pfm_pkg::DATA_W-1:0] WDATA_I,
   input wire logic WE_I,
   input wire logic RE_I,
   output logic [pfm_pkg::DATA_W-1:0] RDATA_O,
   input wire logic LINK_CLK_I,
   input wire logic RX_BIT_I,
   output logic TX_BIT_O,
   output logic TX_ACTIVE_O,
   output logic RX_ACTIVE_O,
   output logic IRQ_O,
   output logic [pfm_pkg::PIN_N-1:0] GP_PIN_O
);
   import pfm_pkg::*;

   localparam int AW = $clog2(DEPTH);
   typedef logic [AW-1:0] pfm_ptr_t;
   typedef logic [AW:0] pfm_lvl_t;

   if (DEPTH < PHYS_DEPTH || DEPTH > 128 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be 64 or 128");
   end

   function automatic pfm_lvl_t margin_bytes(input logic [1:0] sel);
      margin_bytes = pfm_lvl_t'(MARGIN_BASE << sel);
   endfunction : margin_bytes

   function automatic logic is_streaming(input logic [1:0] m);
      is_streaming = (m == PFM_EXTEND) || (m == PFM_INFINITE);
   endfunction : is_streaming

   logic [7:0] tx_mem [DEPTH];
   logic [7:0] rx_mem [DEPTH];
   logic tx_wr_en, rx_wr_en;
   logic [7:0] rx_wr_data;

   logic [2:0] sync_reg, sync_next;
   logic [1:0] rxs_reg, rxs_next;
   logic [1:0] mode_reg, mode_next;
   logic ule_reg, ule_next;
   logic [SA_W-1:0] sa_reg, sa_next;
   logic [7:0] txlen_reg, txlen_next, rxlen_reg, rxlen_next;
   logic [4:0] margin_reg, margin_next;
   logic [GPSEL_W*PIN_N-1:0] gpsel_reg, gpsel_next;
   logic lt_reg, lt_next, txd_reg, txd_next, rxd_reg, rxd_next, uf_reg, uf_next;
   pfm_ptr_t tx_wptr_reg, tx_wptr_next, tx_rptr_reg, tx_rptr_next;
   pfm_ptr_t rx_wptr_reg, rx_wptr_next, rx_rptr_reg, rx_rptr_next;
   pfm_lvl_t tx_lvl_reg, tx_lvl_next, rx_lvl_reg, rx_lvl_next;
   pfm_state_e tx_st_reg, tx_st_next, rx_st_reg, rx_st_next;
   logic [7:0] tx_rem_reg, tx_rem_next, rx_rem_reg, rx_rem_next;
   logic [7:0] tx_sh_reg, tx_sh_next, rx_sh_reg, rx_sh_next;
   logic [2:0] tx_bit_reg, tx_bit_next, rx_bit_reg, rx_bit_next;
   logic txo_reg, txo_next, rx_hdr_reg, rx_hdr_next;
   logic [7:0] rdata_reg, rdata_next;

   logic tick, streaming, unbounded, tx_push, tx_pop, rx_push, rx_pop;
   logic [7:0] rx_byte;
   pfm_lvl_t mthr;

   always_comb begin
      sync_next = {sync_reg[1:0], LINK_CLK_I};
      rxs_next = {rxs_reg[0], RX_BIT_I};
      tick = sync_reg[1] & ~sync_reg[2];
      streaming = is_streaming(mode_reg);
      // unbounded length only in streaming modes
      unbounded = ule_reg & streaming;
      mthr = margin_bytes(margin_reg[F_MARGIN_SEL +: 2]);
      mode_next = mode_reg;
      ule_next = ule_reg;
      sa_next = sa_reg;
      txlen_next = txlen_reg;
      rxlen_next = rxlen_reg;
      margin_next = margin_reg;
      gpsel_next = gpsel_reg;
      lt_next = lt_reg;
      txd_next = txd_reg;
      rxd_next = rxd_reg;
      uf_next = uf_reg;
      tx_wptr_next = tx_wptr_reg;
      tx_rptr_next = tx_rptr_reg;
      rx_wptr_next = rx_wptr_reg;
      rx_rptr_next = rx_rptr_reg;
      tx_st_next = tx_st_reg;
      rx_st_next = rx_st_reg;
      tx_rem_next = tx_rem_reg;
      rx_rem_next = rx_rem_reg;
      tx_sh_next = tx_sh_reg;
      rx_sh_next = rx_sh_reg;
      tx_bit_next = tx_bit_reg;
      rx_bit_next = rx_bit_reg;
      txo_next = txo_reg;
      rx_hdr_next = rx_hdr_reg;
      rdata_next = '0;
      tx_push = 1'b0;
      tx_pop = 1'b0;
      rx_push = 1'b0;
      rx_pop = 1'b0;
      tx_wr_en = 1'b0;
      rx_wr_en = 1'b0;
      rx_byte = {rx_sh_reg[6:0], rxs_reg[1]};
      rx_wr_data = rx_byte;

      // register writes
      if (WE_I) begin
         unique case (ADDR_I)
            A_CTRL: begin
               mode_next = WDATA_I[F_MODE +: 2];
               ule_next = WDATA_I[F_UNBOUNDED];
            end
            A_TX_START: sa_next = WDATA_I[SA_W-1:0];
            A_TX_LEN: begin
               txlen_next = WDATA_I;
               if (tx_st_reg == PFM_RUN && streaming) begin
                  tx_rem_next = WDATA_I;
               end
            end
            A_RX_LEN: begin
               rxlen_next = WDATA_I;
               if (rx_st_reg == PFM_RUN && streaming && !rx_hdr_reg) begin
                  rx_rem_next = WDATA_I;
               end
            end
            A_MARGIN: margin_next = WDATA_I[4:0];
            A_GPSEL_LO: gpsel_next[5:0] = WDATA_I[5:0];
            A_GPSEL_HI: gpsel_next[11:6] = WDATA_I[5:0];
            A_STATUS: begin
               // cleared only by host write of one
               if (WDATA_I[F_LT_FLAG]) lt_next = 1'b0;
               if (WDATA_I[F_TX_DONE]) txd_next = 1'b0;
               if (WDATA_I[F_RX_DONE]) rxd_next = 1'b0;
               if (WDATA_I[F_UNDERFLOW]) uf_next = 1'b0;
            end
            A_TX_DATA: begin
               if (tx_lvl_reg < pfm_lvl_t'(DEPTH)) begin
                  tx_wr_en = 1'b1;
                  tx_push = 1'b1;
                  tx_wptr_next = tx_wptr_reg + pfm_ptr_t'(1);
               end
            end
            default: ;
         endcase
      end

      // register reads, data one cycle later
      if (RE_I) begin
         unique case (ADDR_I)
            A_CTRL: rdata_next = {5'h00, ule_reg, mode_reg};
            A_TX_START: rdata_next = {2'h0, sa_reg};
            A_TX_LEN: rdata_next = txlen_reg;
            A_RX_LEN: rdata_next = rxlen_reg;
            A_MARGIN: rdata_next = {3'h0, margin_reg};
            A_GPSEL_LO: rdata_next = {2'h0, gpsel_reg[5:0]};
            A_GPSEL_HI: rdata_next = {2'h0, gpsel_reg[11:6]};
            A_STATUS: rdata_next = {2'h0, uf_reg, rx_st_reg == PFM_RUN,
                                    tx_st_reg == PFM_RUN, rxd_reg, txd_reg, lt_reg};
            A_RX_DATA: begin
               rdata_next = rx_mem[rx_rptr_reg];
               if (rx_lvl_reg != '0) begin
                  rx_pop = 1'b1;
                  rx_rptr_next = rx_rptr_reg + pfm_ptr_t'(1);
               end
            end
            A_TX_LEVEL: rdata_next = 8'(tx_lvl_reg);
            A_RX_LEVEL: rdata_next = 8'(rx_lvl_reg);
            default: rdata_next = '0;
         endcase
      end

      // transmit engine
      unique case (tx_st_reg)
         PFM_IDLE: begin
            if (WE_I && ADDR_I == A_CMD && WDATA_I[F_TX_GO]) begin
               tx_st_next = PFM_RUN;
               tx_rem_next = txlen_reg;
               tx_bit_next = 3'h0;
               if (mode_reg == PFM_SIMPLE) tx_rptr_next = '0;
               else if (mode_reg == PFM_BLOCK) tx_rptr_next = pfm_ptr_t'(sa_reg);
            end
         end
         PFM_RUN: begin
            if (tick) begin
               if (tx_bit_reg == 3'h0) begin
                  if (!unbounded && tx_rem_reg == 8'h00) begin
                     tx_st_next = PFM_IDLE;
                     txo_next = 1'b0;
                     txd_next = 1'b1;
                  end else if (streaming && tx_lvl_reg == '0) begin
                     tx_st_next = PFM_IDLE;
                     txo_next = 1'b0;
                     uf_next = 1'b1;
                     txd_next = 1'b1;
                  end else begin
                     txo_next = tx_mem[tx_rptr_reg][7];
                     tx_sh_next = {tx_mem[tx_rptr_reg][6:0], 1'b0};
                     tx_bit_next = 3'h7;
                     tx_rptr_next = tx_rptr_reg + pfm_ptr_t'(1);
                     tx_pop = streaming;
                     if (!unbounded) tx_rem_next = tx_rem_reg - 8'h01;
                  end
               end else begin
                  txo_next = tx_sh_reg[7];
                  tx_sh_next = {tx_sh_reg[6:0], 1'b0};
                  tx_bit_next = tx_bit_reg - 3'h1;
               end
            end
         end
      endcase

      // receive engine
      unique case (rx_st_reg)
         PFM_IDLE: begin
            if (WE_I && ADDR_I == A_CMD && WDATA_I[F_RX_GO]) begin
               rx_st_next = PFM_RUN;
               rx_rem_next = rxlen_reg;
               rx_bit_next = 3'h0;
               rx_hdr_next = margin_reg[F_LEN_BYTE_EN];
               if (!streaming) begin
                  rx_wptr_next = '0;
                  rx_rptr_next = '0;
                  rx_pop = 1'b0;
               end
               if (!margin_reg[F_LEN_BYTE_EN] && rxlen_reg == 8'h00 && !unbounded) begin
                  rx_st_next = PFM_IDLE;
                  rxd_next = 1'b1;
               end
            end
         end
         PFM_RUN: begin
            if (tick) begin
               rx_sh_next = rx_byte;
               rx_bit_next = rx_bit_reg + 3'h1;
               if (rx_bit_reg == 3'h7) begin
                  if (rx_hdr_reg) begin
                     rx_hdr_next = 1'b0;
                     rx_rem_next = rx_byte;
                     if (rx_byte == 8'h00 && !unbounded) begin
                        rx_st_next = PFM_IDLE;
                        rxd_next = 1'b1;
                     end
                  end else begin
                     if (rx_lvl_reg < pfm_lvl_t'(DEPTH)) begin
                        rx_wr_en = 1'b1;
                        rx_push = 1'b1;
                        rx_wptr_next = rx_wptr_reg + pfm_ptr_t'(1);
                     end
                     if (!unbounded) begin
                        rx_rem_next = rx_rem_reg - 8'h01;
                        if (rx_rem_reg == 8'h01) begin
                           rx_st_next = PFM_IDLE;
                           rxd_next = 1'b1;
                        end
                     end
                  end
               end
            end
         end
      endcase

      tx_lvl_next = tx_lvl_reg + pfm_lvl_t'(tx_push) - pfm_lvl_t'(tx_pop);
      rx_lvl_next = rx_lvl_reg + pfm_lvl_t'(rx_push) - pfm_lvl_t'(rx_pop);
      if (rx_st_reg == PFM_IDLE && rx_st_next == PFM_RUN && !streaming) rx_lvl_next = '0;

      // level threshold detect (tx below margin, rx at or above margin), set wins over clear
      if (margin_reg[F_MARGIN_EN] && streaming) begin
         if (tx_st_reg == PFM_RUN && tx_lvl_reg < mthr) lt_next = 1'b1;
         if (rx_st_reg == PFM_RUN && rx_lvl_reg >= mthr) lt_next = 1'b1;
      end

      if (WE_I && ADDR_I == A_CMD) begin
         if (WDATA_I[F_TX_RESET]) begin
            tx_wptr_next = '0;
            tx_rptr_next = '0;
            tx_lvl_next = '0;
            tx_st_next = PFM_IDLE;
            txo_next = 1'b0;
         end
         if (WDATA_I[F_RX_RESET]) begin
            rx_wptr_next = '0;
            rx_rptr_next = '0;
            rx_lvl_next = '0;
            rx_st_next = PFM_IDLE;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         sync_reg <= '0;
         rxs_reg <= '0;
         mode_reg <= PFM_SIMPLE;
         ule_reg <= 1'b0;
         sa_reg <= '0;
         txlen_reg <= '0;
         rxlen_reg <= '0;
         margin_reg <= '0;
         gpsel_reg <= '0;
         lt_reg <= 1'b0;
         txd_reg <= 1'b0;
         rxd_reg <= 1'b0;
         uf_reg <= 1'b0;
         tx_wptr_reg <= '0;
         tx_rptr_reg <= '0;
         rx_wptr_reg <= '0;
         rx_rptr_reg <= '0;
         tx_lvl_reg <= '0;
         rx_lvl_reg <= '0;
         tx_st_reg <= PFM_IDLE;
         rx_st_reg <= PFM_IDLE;
         tx_rem_reg <= '0;
         rx_rem_reg <= '0;
         tx_sh_reg <= '0;
         rx_sh_reg <= '0;
         tx_bit_reg <= '0;
         rx_bit_reg <= '0;
         txo_reg <= 1'b0;
         rx_hdr_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         sync_reg <= sync_next;
         rxs_reg <= rxs_next;
         mode_reg <= mode_next;
         ule_reg <= ule_next;
         sa_reg <= sa_next;
         txlen_reg <= txlen_next;
         rxlen_reg <= rxlen_next;
         margin_reg <= margin_next;
         gpsel_reg <= gpsel_next;
         lt_reg <= lt_next;
         txd_reg <= txd_next;
         rxd_reg <= rxd_next;
         uf_reg <= uf_next;
         tx_wptr_reg <= tx_wptr_next;
         tx_rptr_reg <= tx_rptr_next;
         rx_wptr_reg <= rx_wptr_next;
         rx_rptr_reg <= rx_rptr_next;
         tx_lvl_reg <= tx_lvl_next;
         rx_lvl_reg <= rx_lvl_next;
         tx_st_reg <= tx_st_next;
         rx_st_reg <= rx_st_next;
         tx_rem_reg <= tx_rem_next;
         rx_rem_reg <= rx_rem_next;
         tx_sh_reg <= tx_sh_next;
         rx_sh_reg <= rx_sh_next;
         tx_bit_reg <= tx_bit_next;
         rx_bit_reg <= rx_bit_next;
         txo_reg <= txo_next;
         rx_hdr_reg <= rx_hdr_next;
         rdata_reg <= rdata_next;
      end
   end

   // buffer storage, no reset on the data
   always_ff @(posedge CLK_I) begin
      if (tx_wr_en) tx_mem[tx_wptr_reg] <= WDATA_I;
      if (rx_wr_en) rx_mem[rx_wptr_reg] <= rx_wr_data;
   end

   assign IRQ_O = (lt_reg & margin_reg[F_LT_IRQ_EN]) | txd_reg | rxd_reg;
   assign RDATA_O = rdata_reg;
   assign TX_BIT_O = txo_reg;
   assign TX_ACTIVE_O = (tx_st_reg == PFM_RUN);
   assign RX_ACTIVE_O = (rx_st_reg == PFM_RUN);

   for (genvar p = 0; p < PIN_N; p++) begin : g_pin
      assign GP_PIN_O[p] = (gpsel_reg[p*GPSEL_W +: GPSEL_W] == GP_IRQ_FUNC) & IRQ_O;
   end
endmodule : pfm_controller

`default_nettype wire

// ===== core/pfm_pkg.sv
// register map, field layout and encodings of the packet fifo mode controller
// assumes one byte-wide register port and a single 250 MHz clock
package pfm_pkg;
   // fifo operating modes, values of the mode field
   typedef enum logic [1:0] {
      PFM_SIMPLE,
      PFM_BLOCK,
      PFM_EXTEND,
      PFM_INFINITE
   } pfm_mode_e;

   typedef enum logic {
      PFM_IDLE,
      PFM_RUN
   } pfm_state_e;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam int SA_W = 6;
   localparam int GPSEL_W = 3;
   localparam int PIN_N = 4;
   localparam int PHYS_DEPTH = 64;

   // register offsets
   localparam logic [3:0] A_CTRL = 4'h0;
   localparam logic [3:0] A_TX_START = 4'h1;
   localparam logic [3:0] A_TX_LEN = 4'h2;
   localparam logic [3:0] A_RX_LEN = 4'h3;
   localparam logic [3:0] A_MARGIN = 4'h4;
   localparam logic [3:0] A_GPSEL_LO = 4'h5;
   localparam logic [3:0] A_GPSEL_HI = 4'h6;
   localparam logic [3:0] A_CMD = 4'h7;
   localparam logic [3:0] A_STATUS = 4'h8;
   localparam logic [3:0] A_TX_DATA = 4'h9;
   localparam logic [3:0] A_RX_DATA = 4'ha;
   localparam logic [3:0] A_TX_LEVEL = 4'hb;
   localparam logic [3:0] A_RX_LEVEL = 4'hc;

   // ctrl fields
   localparam int F_MODE = 0;
   localparam int F_UNBOUNDED = 2;
   // margin register fields
   localparam int F_MARGIN_SEL = 0;
   localparam int F_MARGIN_EN = 2;
   localparam int F_LT_IRQ_EN = 3;
   localparam int F_LEN_BYTE_EN = 4;
   // command bits
   localparam int F_TX_RESET = 0;
   localparam int F_RX_RESET = 1;
   localparam int F_TX_GO = 2;
   localparam int F_RX_GO = 3;
   // status bits
   localparam int F_LT_FLAG = 0;
   localparam int F_TX_DONE = 1;
   localparam int F_RX_DONE = 2;
   localparam int F_TX_BUSY = 3;
   localparam int F_RX_BUSY = 4;
   localparam int F_UNDERFLOW = 5;

   localparam logic [2:0] GP_IRQ_FUNC = 3'h5;
   localparam logic [7:0] MARGIN_BASE = 8'h04;
endpackage : pfm_pkg

// ===== sim/pfm_controller_sva.sv
// assertion checker on the pins of the fifo mode controller
// assumes one clock domain with an active-high reset
`timescale 1ns/1ps
`default_nettype none
module pfm_controller_sva #(
   parameter int DEPTH = 64
) (
   input wire logic CLK_I,
   input wire logic RST_I,
   input wire logic [pfm_pkg::ADDR_W-1:0] ADDR_I,
   input wire logic [pfm_pkg::DATA_W-1:0] WDATA_I,
   input wire logic WE_I,
   input wire logic LINK_CLK_I,
   input wire logic TX_BIT_O,
   input wire logic TX_ACTIVE_O,
   input wire logic RX_ACTIVE_O,
   input wire logic IRQ_O,
   input wire logic [pfm_pkg::PIN_N-1:0] GP_PIN_O
);
   import pfm_pkg::*;
   logic cmd_wr;
   assign cmd_wr = WE_I && (ADDR_I == A_CMD);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   tx_start_a: assert property (cmd_wr && WDATA_I[F_TX_GO] && !WDATA_I[F_TX_RESET]
      && !TX_ACTIVE_O |=> TX_ACTIVE_O) else $error("tx start not taken");
   rx_start_a: assert property (cmd_wr && WDATA_I[F_RX_GO] && !WDATA_I[F_RX_RESET]
      && !RX_ACTIVE_O |=> RX_ACTIVE_O || IRQ_O) else $error("rx start not taken");
   gp_route_a: assert property (!IRQ_O |-> GP_PIN_O == 4'h0)
      else $error("pin high without irq");
   tx_bit_hold_a: assert property ($stable(LINK_CLK_I) [*8] |=> $stable(TX_BIT_O))
      else $error("tx bit moved without link edge");
   tx_end_low_a: assert property ($fell(TX_ACTIVE_O) |-> !TX_BIT_O)
      else $error("tx bit high after end");
   tx_done_irq_a: assert property ($fell(TX_ACTIVE_O) |-> IRQ_O)
      else $error("no irq at tx end");
   rx_done_irq_a: assert property ($fell(RX_ACTIVE_O) |-> IRQ_O)
      else $error("no irq at rx end");
   tx_end_tick_a: assert property ($fell(TX_ACTIVE_O) |-> $past(LINK_CLK_I))
      else $error("tx ended off a link tick");
endmodule : pfm_controller_sva

bind pfm_controller pfm_controller_sva #(.DEPTH(DEPTH)) u_sva (
   .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WE_I(WE_I),
   .LINK_CLK_I(LINK_CLK_I), .TX_BIT_O(TX_BIT_O), .TX_ACTIVE_O(TX_ACTIVE_O),
   .RX_ACTIVE_O(RX_ACTIVE_O), .IRQ_O(IRQ_O), .GP_PIN_O(GP_PIN_O)
);
`default_nettype wire

// ===== sim/pfm_link_model.sv
// link side model: bit clock only inside frames, feeds rx bits, collects tx bits
// assumes the controller takes each bit slot on the rising link edge
`timescale 1ns/1ps
`default_nettype none
module pfm_link_model (
   output logic link_clk_o,
   output logic rx_bit_o,
   input wire logic tx_bit_i
);
   logic [7:0] rx_byte[$];
   logic [7:0] tx_byte[$];
   initial begin
      link_clk_o = 1'b0;
      rx_bit_o = 1'b0;
   end
   // one call is one frame of n bit slots
   task automatic frame(input int n);
      logic [7:0] cur;
      logic [7:0] sh;
      cur = 8'h00;
      sh = 8'h00;
      for (int i = 0; i < n; i++) begin
         if (i % 8 == 0) cur = (rx_byte.size() > 0) ? rx_byte.pop_front() : ~cur;
         rx_bit_o = cur[7 - i % 8];
         #31.25 link_clk_o = 1'b1;
         #62.5 link_clk_o = 1'b0;
         sh = {sh[6:0], tx_bit_i};
         if (i % 8 == 7) tx_byte.push_back(sh);
         #31.25;
      end
      // released line shows no stale level
      rx_bit_o = ~rx_bit_o;
   endtask : frame
endmodule : pfm_link_model
`default_nettype wire

// ===== sim/test_pfm_controller.sv
// self-checking bench for the packet fifo mode controller
// assumes the link model alone drives the bit clock and rx line
`timescale 1ns/1ps
`default_nettype none
module test_pfm_controller;
   import pfm_pkg::*;
   logic CLK_I;
   logic RST_I;
   logic WE_I;
   logic RE_I;
   logic [ADDR_W-1:0] ADDR_I;
   logic [DATA_W-1:0] WDATA_I;
   logic [DATA_W-1:0] RDATA_O;
   logic LINK_CLK_I;
   logic RX_BIT_I;
   logic TX_BIT_O;
   logic TX_ACTIVE_O;
   logic RX_ACTIVE_O;
   logic IRQ_O;
   logic [PIN_N-1:0] GP_PIN_O;
   int n_fail = 0;
   int n_checks = 0;

   pfm_controller #(.DEPTH(64)) u_dut (
      .CLK_I(CLK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WE_I(WE_I),
      .RE_I(RE_I), .RDATA_O(RDATA_O), .LINK_CLK_I(LINK_CLK_I), .RX_BIT_I(RX_BIT_I),
      .TX_BIT_O(TX_BIT_O), .TX_ACTIVE_O(TX_ACTIVE_O), .RX_ACTIVE_O(RX_ACTIVE_O),
      .IRQ_O(IRQ_O), .GP_PIN_O(GP_PIN_O)
   );
   pfm_link_model u_link (.link_clk_o(LINK_CLK_I), .rx_bit_o(RX_BIT_I), .tx_bit_i(TX_BIT_O));

   initial begin
      CLK_I = 1'b0;
      forever #2 CLK_I = ~CLK_I;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WE_I <= 1'b1;
      @(posedge CLK_I);
      WE_I <= 1'b0;
      #1;
   endtask : wr

   // read strobe, then compare the byte of the following cycle
   task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
      @(posedge CLK_I);
      ADDR_I <= a;
      RE_I <= 1'b1;
      @(posedge CLK_I);
      RE_I <= 1'b0;
      #1;
      chk(RDATA_O, exp);
   endtask : rdc

   task automatic fill(input int n, input logic [7:0] base);
      for (int i = 0; i < n; i++) begin
         wr(A_TX_DATA, base + 8'(i));
      end
   endtask : fill

   task automatic start_tx();
      u_link.tx_byte.delete();
      wr(A_CMD, 8'h04);
   endtask : start_tx

   task automatic t_simple();
      rdc(A_STATUS, 8'h00);
      rdc(4'hf, 8'h00);
      fill(1, 8'h77);
      wr(A_CMD, 8'h03);
      rdc(A_TX_LEVEL, 8'h00);
      wr(A_TX_START, 8'h00);
      fill(2, 8'ha5);
      wr(A_TX_LEN, 8'h02);
      for (int r = 0; r < 2; r++) begin
         start_tx();
         u_link.frame(26);
         chk(u_link.tx_byte[0], 8'ha5);
         chk(u_link.tx_byte[1], 8'ha6);
         chk(u_link.tx_byte[2], 8'h00);
         chk({7'h0, IRQ_O}, 8'h01);
         rdc(A_STATUS, 8'h02);
         rdc(A_TX_LEVEL, 8'h02);
         wr(A_STATUS, 8'h02);
      end
   endtask : t_simple

   task automatic t_block();
      wr(A_CTRL, 8'h01);
      wr(A_TX_START, 8'h01);
      rdc(A_TX_START, 8'h01);
      wr(A_TX_LEN, 8'h01);
      start_tx();
      u_link.frame(10);
      chk(u_link.tx_byte[0], 8'ha6);
      wr(A_GPSEL_LO, 8'h05);
      wr(A_GPSEL_HI, 8'h2d);
      rdc(A_GPSEL_LO, 8'h05);
      rdc(A_GPSEL_HI, 8'h2d);
      chk({4'h0, GP_PIN_O}, 8'h0d);
      wr(A_STATUS, 8'h02);
      chk({4'h0, GP_PIN_O}, 8'h00);
   endtask : t_block

   task automatic t_margin();
      int m;
      for (int k = 0; k < 4; k++) begin
         m = 4 << k;
         wr(A_CMD, 8'h01);
         wr(A_CTRL, 8'h02);
         wr(A_TX_START, 8'h00);
         wr(A_MARGIN, 8'(k) | 8'h04 | (k[0] ? 8'h08 : 8'h00));
         fill(m, 8'h40);
         wr(A_TX_LEN, 8'(m));
         start_tx();
         rdc(A_STATUS, 8'h08);
         u_link.frame(8);
         rdc(A_STATUS, 8'h09);
         u_link.frame(8 * m - 6);
         rdc(A_TX_LEVEL, 8'h00);
         chk(u_link.tx_byte[m - 1], 8'h40 + 8'(m - 1));
         rdc(A_STATUS, 8'h03);
         wr(A_STATUS, 8'h02);
         chk({7'h0, IRQ_O}, {7'h0, k[0]});
         rdc(A_STATUS, 8'h01);
         wr(A_STATUS, 8'h01);
         rdc(A_STATUS, 8'h00);
      end
   endtask : t_margin

   task automatic t_stream_end();
      wr(A_MARGIN, 8'h00);
      wr(A_CMD, 8'h01);
      fill(2, 8'h11);
      wr(A_TX_LEN, 8'h05);
      start_tx();
      u_link.frame(34);
      chk(u_link.tx_byte[1], 8'h12);
      rdc(A_STATUS, 8'h22);
      wr(A_STATUS, 8'h22);
      wr(A_CTRL, 8'h07);
      rdc(A_CTRL, 8'h07);
      wr(A_CMD, 8'h01);
      fill(4, 8'h30);
      wr(A_TX_LEN, 8'h01);
      start_tx();
      u_link.frame(20);
      chk({7'h0, TX_ACTIVE_O}, 8'h01);
      wr(A_CTRL, 8'h03);
      wr(A_TX_LEN, 8'h01);
      u_link.frame(14);
      rdc(A_STATUS, 8'h02);
      wr(A_STATUS, 8'h02);
   endtask : t_stream_end

   task automatic t_rx();
      wr(A_CTRL, 8'h00);
      wr(A_CMD, 8'h02);
      wr(A_RX_LEN, 8'h02);
      u_link.rx_byte.push_back(8'h96);
      u_link.rx_byte.push_back(8'h0f);
      wr(A_CMD, 8'h08);
      chk({7'h0, RX_ACTIVE_O}, 8'h01);
      u_link.frame(18);
      rdc(A_STATUS, 8'h04);
      rdc(A_RX_LEVEL, 8'h02);
      rdc(A_RX_DATA, 8'h96);
      rdc(A_RX_DATA, 8'h0f);
      wr(A_STATUS, 8'h04);
      wr(A_MARGIN, 8'h10);
      wr(A_RX_LEN, 8'h00);
      u_link.rx_byte.push_back(8'h01);
      u_link.rx_byte.push_back(8'h5a);
      wr(A_CMD, 8'h08);
      u_link.frame(18);
      rdc(A_RX_LEVEL, 8'h01);
      rdc(A_RX_DATA, 8'h5a);
      // streaming receive with margin handshake
      wr(A_STATUS, 8'h04);
      wr(A_CTRL, 8'h02);
      wr(A_MARGIN, 8'h04);
      wr(A_CMD, 8'h02);
      wr(A_RX_LEN, 8'h06);
      for (int i = 0; i < 6; i++) begin
         u_link.rx_byte.push_back(8'hc0 + 8'(i));
      end
      wr(A_CMD, 8'h08);
      u_link.frame(32);
      rdc(A_STATUS, 8'h11);
      for (int i = 0; i < 4; i++) begin
         rdc(A_RX_DATA, 8'hc0 + 8'(i));
      end
      wr(A_STATUS, 8'h01);
      u_link.frame(16);
      rdc(A_STATUS, 8'h04);
      rdc(A_RX_DATA, 8'hc4);
      rdc(A_RX_DATA, 8'hc5);
   endtask : t_rx

   initial begin
      RST_I = 1'b1;
      WE_I = 1'b0;
      RE_I = 1'b0;
      ADDR_I = 4'h0;
      WDATA_I = 8'h00;
      repeat (12) @(posedge CLK_I);
      RST_I <= 1'b0;
      t_simple();
      t_block();
      t_margin();
      t_stream_end();
      t_rx();
      report_and_stop();
   end

   // hang guard
   initial begin
      repeat (100000) @(posedge CLK_I);
      n_fail++;
      report_and_stop();
   end
endmodule : test_pfm_controller
`default_nettype wire
